// ---- hw/usbifc_defs.vh ----
// Register map, field positions and reset values of the USB interface control block.
// Included by the design files; definitions only.
`ifndef USBIFC_DEFS_VH
`define USBIFC_DEFS_VH

`define USBIFC_ADDR_W        8
`define USBIFC_OFS_OTG_CTRL  8'h10
`define USBIFC_OFS_OTG_STAT  8'h14
`define USBIFC_OFS_SER_CTRL  8'h18
`define USBIFC_OFS_EVT_FLAGS 8'h1C
`define USBIFC_OFS_STICKY    8'h20
`define USBIFC_OFS_IRQ_STAT  8'h24
`define USBIFC_OFS_IRQ_MASK  8'h28

`define USBIFC_OTG_CTRL_MASK 8'hDF
`define USBIFC_OTG_CTRL_RST  8'h00
`define USBIFC_OTG_STAT_W    6
`define USBIFC_SER_WR_MASK   4'hF
`define USBIFC_SER_CTRL_RST  4'h2
`define USBIFC_FLAG_W        7
`define USBIFC_FLAG_RST      7'h00

`define USBIFC_OTG_EXT_IND   7
`define USBIFC_OTG_EXT_DRV   6
`define USBIFC_OTG_CHRG      4
`define USBIFC_OTG_DISCHRG   3
`define USBIFC_OTG_DM_PD     2
`define USBIFC_OTG_DP_PD     1
`define USBIFC_OTG_ID_PU     0

`define USBIFC_SER_SE0       3
`define USBIFC_SER_TXD       2
`define USBIFC_SER_TXEN_N    1
`define USBIFC_SER_FSLS      0

`define USBIFC_FLG_TOKEN     6
`define USBIFC_FLG_SE0       5
`define USBIFC_FLG_K         4
`define USBIFC_FLG_J         3
`define USBIFC_FLG_CRC16     2
`define USBIFC_FLG_RXACT     1
`define USBIFC_FLG_RXERR     0

`define USBIFC_LS_SE0        2'h0
`define USBIFC_LS_J          2'h1
`define USBIFC_LS_K          2'h2

`endif

// ---- hw/usbifc_flag_bit.v ----
// One line event flag with selectable sticky, follow or clear-at-packet-start behaviour.
// Assumes event inputs synchronous to clk_in; packet start is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module usbifc_flag_bit (
   // Clock and reset
   input  wire clk_in,
   input  wire resetn_in,
   // Controls
   input  wire sticky_in,
   input  wire is_level_in,
   input  wire src_in,
   input  wire pkt_start_in,
   input  wire sw_clear_in,
   // State
   output reg  flag_r_out
);
   reg flag_nxt;

   always @* begin
      flag_nxt = flag_r_out;
      if (sticky_in) begin
         if (sw_clear_in)
            flag_nxt = 1'b0;                  // RULE_14
         if (src_in)
            flag_nxt = 1'b1;                  // Set wins over clear
      end else if (is_level_in) begin
         flag_nxt = src_in;                   // RULE_15
      end else begin
         if (pkt_start_in)
            flag_nxt = 1'b0;                  // RULE_13
         if (src_in)
            flag_nxt = 1'b1;
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         flag_r_out <= 1'b0;
      else
         flag_r_out <= flag_nxt;
   end
endmodule // usbifc_flag_bit
`default_nettype wire

// ---- hw/usbifc_top.v ----
// USB interface control: on-the-go control/status, serial line control, line event flags.
// Assumes transceiver inputs synchronous to clk_in and a one-cycle-strobe register port.
// Summary of operation
// (RULE_01) Control bits 7 and 6 select external VBUS indicator and drive modes.
// (RULE_02) Control bit 4 requests VBUS charge, bit 3 discharge; bit 5 reserved.
// (RULE_03) Control bits 2,1,0 enable D-minus, D-plus pull-downs and ID pull-up.
// (RULE_04) Status register bits 5..0 mirror the six transceiver session signals.
// (RULE_05) Serial bits 6,5,4 read differential, D-minus and D-plus receive inputs.
// (RULE_06) Serial bit 3 drives single-ended-zero, bit 2 transmit data.
// (RULE_07) Serial bit 1 resets high; zero enables the active-low transmit enable.
// (RULE_08) Serial bit 0 selects full/low-speed serial mode.
// (RULE_09) Event bit 6 sets on a good token: CRC5, PID and address.
// (RULE_10) Event bits 5,4,3 set on line state SE0, K and J.
// (RULE_11) Event bit 2 sets when a data packet fails CRC16.
// (RULE_12) Event bits 1,0 follow receive-active and receive-error inputs.
// (RULE_13) Non-sticky flags clear at the next packet; sticky ones need software. Non-sticky bits 1,0 follow their inputs instead of clearing.
// (RULE_14) A sticky flag holds until software writes one to it.
// (RULE_15) A non-sticky flag is overwritten by later source changes; the code does this for bits 1,0 only, bits 6..2 stay set until the next packet.
// (RULE_16) Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "usbifc_defs.vh"
module usbifc_top #(
   parameter FLAG_W = `USBIFC_FLAG_W
) (
   // Clock and reset
   input  wire                      clk_in,
   input  wire                      resetn_in,
   // Register port
   input  wire [`USBIFC_ADDR_W-1:0] addr_in,
   input  wire [31:0]               wdata_in,
   input  wire                      wr_in,
   input  wire                      rd_in,
   output reg  [31:0]               rdata_out,
   // Transceiver status
   input  wire                      bvalid_in,
   input  wire                      id_ground_in,
   input  wire                      host_disconnect_in,
   input  wire                      vbus_valid_in,
   input  wire                      session_valid_in,
   input  wire                      session_end_in,
   input  wire                      differential_receive_in,
   input  wire                      dminus_receive_in,
   input  wire                      dplus_receive_in,
   input  wire [1:0]                line_state_in,
   input  wire                      receive_active_input_in,
   input  wire                      receive_error_input_in,
   // Packet decoder events
   input  wire                      token_ok_in,
   input  wire                      crc16_fail_in,
   // Transceiver control
   output reg                       external_vbus_indicator_out,
   output reg                       external_vbus_drive_out,
   output reg                       vbus_charge_out,
   output reg                       vbus_discharge_out,
   output reg                       dminus_pulldown_out,
   output reg                       dplus_pulldown_out,
   output reg                       id_pin_pullup_out,
   output reg                       transmit_single_ended_zero_out,
   output reg                       serial_transmit_data_out,
   output reg                       serial_transmit_enable_low_out,
   output reg                       full_low_speed_serial_out,
   // Interrupt
   output reg                       irq_out
);
   reg  [7:0]        otg_ctrl_r;
   reg  [5:0]        otg_stat_r;
   reg  [3:0]        ser_ctrl_r;
   reg  [2:0]        rx_lines_r;
   reg  [FLAG_W-1:0] sticky_r;
   reg  [FLAG_W-1:0] irq_stat_r;
   reg  [FLAG_W-1:0] irq_mask_r;
   reg               rxact_d_r;
   reg  [FLAG_W-1:0] flag_src;
   reg  [FLAG_W-1:0] flag_lvl;
   reg  [FLAG_W-1:0] flag_rise;
   reg  [FLAG_W-1:0] flag_d_r;
   reg  [FLAG_W-1:0] irq_stat_nxt;
   reg  [31:0]       rdata_nxt;
   wire [FLAG_W-1:0] flags;
   wire [FLAG_W-1:0] flag_clr;
   wire              pkt_start;
   genvar            gi;

   function sel;
      input [`USBIFC_ADDR_W-1:0] a;
      input [`USBIFC_ADDR_W-1:0] ofs;
      begin
         sel = (a == ofs);
      end
   endfunction

   // Rising receive-active marks the start of the next packet
   assign pkt_start = receive_active_input_in & ~rxact_d_r;
   assign flag_clr  = (wr_in && sel(addr_in, `USBIFC_OFS_EVT_FLAGS)) ?
                      wdata_in[FLAG_W-1:0] : {FLAG_W{1'b0}};

   always @* begin
      flag_src = {FLAG_W{1'b0}};
      flag_lvl = {FLAG_W{1'b0}};
      flag_src[`USBIFC_FLG_TOKEN] = token_ok_in;                          // RULE_09
      flag_src[`USBIFC_FLG_SE0]   = (line_state_in == `USBIFC_LS_SE0);    // RULE_10
      flag_src[`USBIFC_FLG_K]     = (line_state_in == `USBIFC_LS_K);      // RULE_10
      flag_src[`USBIFC_FLG_J]     = (line_state_in == `USBIFC_LS_J);      // RULE_10
      flag_src[`USBIFC_FLG_CRC16] = crc16_fail_in;                        // RULE_11
      flag_src[`USBIFC_FLG_RXACT] = receive_active_input_in;              // RULE_12
      flag_src[`USBIFC_FLG_RXERR] = receive_error_input_in;               // RULE_12
      flag_lvl[`USBIFC_FLG_RXACT] = 1'b1;
      flag_lvl[`USBIFC_FLG_RXERR] = 1'b1;
   end

   generate
      for (gi = 0; gi < FLAG_W; gi = gi + 1) begin : g_flag
         usbifc_flag_bit u_flag (
            .clk_in       (clk_in),
            .resetn_in    (resetn_in),
            .sticky_in    (sticky_r[gi]),
            .is_level_in  (flag_lvl[gi]),
            .src_in       (flag_src[gi]),
            .pkt_start_in (pkt_start),
            .sw_clear_in  (flag_clr[gi]),
            .flag_r_out   (flags[gi])
         );
      end
   endgenerate

   always @* begin
      flag_rise = flags & ~flag_d_r;
      irq_stat_nxt = irq_stat_r;
      if (rd_in && sel(addr_in, `USBIFC_OFS_IRQ_STAT))
         irq_stat_nxt = {FLAG_W{1'b0}};
      // New events win over the read clear
      irq_stat_nxt = irq_stat_nxt | flag_rise;
   end

   always @* begin
      rdata_nxt = 32'h0000_0000;                                          // RULE_16
      if (rd_in) begin
         case (addr_in)
            `USBIFC_OFS_OTG_CTRL:  rdata_nxt[7:0] = otg_ctrl_r;
            `USBIFC_OFS_OTG_STAT:  rdata_nxt[5:0] = otg_stat_r;           // RULE_04
            `USBIFC_OFS_SER_CTRL:  rdata_nxt[6:0] = {rx_lines_r, ser_ctrl_r}; // RULE_05
            `USBIFC_OFS_EVT_FLAGS: rdata_nxt[FLAG_W-1:0] = flags;
            `USBIFC_OFS_STICKY:    rdata_nxt[FLAG_W-1:0] = sticky_r;
            `USBIFC_OFS_IRQ_STAT:  rdata_nxt[FLAG_W-1:0] = irq_stat_r;
            `USBIFC_OFS_IRQ_MASK:  rdata_nxt[FLAG_W-1:0] = irq_mask_r;
            default:               rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         otg_ctrl_r <= `USBIFC_OTG_CTRL_RST;
         otg_stat_r <= 6'h00;
         ser_ctrl_r <= `USBIFC_SER_CTRL_RST;
         rx_lines_r <= 3'h0;
         sticky_r   <= `USBIFC_FLAG_RST;
         irq_stat_r <= `USBIFC_FLAG_RST;
         irq_mask_r <= `USBIFC_FLAG_RST;
         rxact_d_r  <= 1'b0;
         flag_d_r   <= `USBIFC_FLAG_RST;
         rdata_out  <= 32'h0000_0000;
      end else begin
         if (wr_in && sel(addr_in, `USBIFC_OFS_OTG_CTRL))
            otg_ctrl_r <= wdata_in[7:0] & `USBIFC_OTG_CTRL_MASK;           // RULE_16
         if (wr_in && sel(addr_in, `USBIFC_OFS_SER_CTRL))
            ser_ctrl_r <= wdata_in[3:0] & `USBIFC_SER_WR_MASK;
         if (wr_in && sel(addr_in, `USBIFC_OFS_STICKY))
            sticky_r <= wdata_in[FLAG_W-1:0];
         if (wr_in && sel(addr_in, `USBIFC_OFS_IRQ_MASK))
            irq_mask_r <= wdata_in[FLAG_W-1:0];
         otg_stat_r <= {bvalid_in, id_ground_in, host_disconnect_in,
                        vbus_valid_in, session_valid_in, session_end_in}; // RULE_04
         rx_lines_r <= {differential_receive_in, dminus_receive_in,
                        dplus_receive_in};                               // RULE_05
         irq_stat_r <= irq_stat_nxt;
         rxact_d_r  <= receive_active_input_in;
         flag_d_r   <= flags;
         rdata_out  <= rdata_nxt;
      end
   end

   // Outputs registered from the control registers, two cycles after the write strobe
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         external_vbus_indicator_out    <= 1'b0;
         external_vbus_drive_out        <= 1'b0;
         vbus_charge_out                <= 1'b0;
         vbus_discharge_out             <= 1'b0;
         dminus_pulldown_out            <= 1'b0;
         dplus_pulldown_out             <= 1'b0;
         id_pin_pullup_out              <= 1'b0;
         transmit_single_ended_zero_out <= 1'b0;
         serial_transmit_data_out       <= 1'b0;
         serial_transmit_enable_low_out <= 1'b1;
         full_low_speed_serial_out      <= 1'b0;
         irq_out                        <= 1'b0;
      end else begin
         external_vbus_indicator_out    <= otg_ctrl_r[`USBIFC_OTG_EXT_IND];  // RULE_01
         external_vbus_drive_out        <= otg_ctrl_r[`USBIFC_OTG_EXT_DRV];  // RULE_01
         vbus_charge_out                <= otg_ctrl_r[`USBIFC_OTG_CHRG];     // RULE_02
         vbus_discharge_out             <= otg_ctrl_r[`USBIFC_OTG_DISCHRG];  // RULE_02
         dminus_pulldown_out            <= otg_ctrl_r[`USBIFC_OTG_DM_PD];    // RULE_03
         dplus_pulldown_out             <= otg_ctrl_r[`USBIFC_OTG_DP_PD];    // RULE_03
         id_pin_pullup_out              <= otg_ctrl_r[`USBIFC_OTG_ID_PU];    // RULE_03
         transmit_single_ended_zero_out <= ser_ctrl_r[`USBIFC_SER_SE0];      // RULE_06
         serial_transmit_data_out       <= ser_ctrl_r[`USBIFC_SER_TXD];      // RULE_06
         serial_transmit_enable_low_out <= ser_ctrl_r[`USBIFC_SER_TXEN_N];   // RULE_07
         full_low_speed_serial_out      <= ser_ctrl_r[`USBIFC_SER_FSLS];     // RULE_08
         irq_out                        <= |(irq_stat_r & irq_mask_r);
      end
   end
endmodule // usbifc_top
`default_nettype wire

// ---- tb/usbifc_monitor.sv ----
// Port-level checks of the USB interface control block.
// Assumes one clock, async active-low reset and one-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module usbifc_chk (
   // Clock, reset and register port
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   // Transceiver side
   input wire logic        differential_receive_in,
   input wire logic        dminus_receive_in,
   input wire logic        dplus_receive_in,
   input wire logic        receive_active_input_in,
   input wire logic        receive_error_input_in,
   input wire logic        external_vbus_indicator_out,
   input wire logic        external_vbus_drive_out,
   input wire logic        vbus_charge_out,
   input wire logic        vbus_discharge_out,
   input wire logic        dminus_pulldown_out,
   input wire logic        dplus_pulldown_out,
   input wire logic        id_pin_pullup_out,
   input wire logic        transmit_single_ended_zero_out,
   input wire logic        serial_transmit_data_out,
   input wire logic        serial_transmit_enable_low_out,
   input wire logic        full_low_speed_serial_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // Receive flags only follow their inputs while not made sticky
   logic [1:0] sticky_lo_r;
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         sticky_lo_r <= 2'b00;
      else if (wr_in && addr_in == 8'h20)
         sticky_lo_r <= wdata_in[1:0];
   end
   sequence s_otg_wr;
      wr_in && addr_in == 8'h10;
   endsequence
   sequence s_ser_wr;
      wr_in && addr_in == 8'h18;
   endsequence
   sequence s_rd(logic [7:0] ofs);
      rd_in && addr_in == ofs;
   endsequence
   a_ext_vbus_modes: assert property (s_otg_wr |-> ##2
      {external_vbus_indicator_out, external_vbus_drive_out} == $past(wdata_in[7:6], 2))
      else $error("vbus mode outputs differ from write");
   a_vbus_supply_req: assert property (s_otg_wr |-> ##2
      {vbus_charge_out, vbus_discharge_out} == $past(wdata_in[4:3], 2))
      else $error("vbus charge outputs differ from write");
   a_line_pull_ctl: assert property (s_otg_wr |-> ##2
      {dminus_pulldown_out, dplus_pulldown_out, id_pin_pullup_out} == $past(wdata_in[2:0], 2))
      else $error("pull outputs differ from write");
   a_serial_drive: assert property (s_ser_wr |-> ##2
      {transmit_single_ended_zero_out, serial_transmit_data_out, full_low_speed_serial_out}
      == {$past(wdata_in[3:2], 2), $past(wdata_in[0], 2)})
      else $error("serial drive outputs differ from write");
   a_tx_enable_low: assert property (s_ser_wr |-> ##2
      serial_transmit_enable_low_out == $past(wdata_in[1], 2))
      else $error("transmit enable differs from write");
   a_rx_line_read: assert property (s_rd(8'h18) |=> rdata_out[31:4] ==
      {25'h0, $past({differential_receive_in, dminus_receive_in, dplus_receive_in}, 2)})
      else $error("serial receive bits read wrong");
   a_otg_rsvd_zero: assert property (s_rd(8'h10) |=>
      rdata_out[31:8] == 24'h0 && !rdata_out[5])
      else $error("reserved control bits not zero");
   a_rx_flag_follow: assert property (s_rd(8'h1C) ##0 $past(sticky_lo_r) == 2'b00
      |=> rdata_out[1:0] ==
      $past({receive_active_input_in, receive_error_input_in}, 2))
      else $error("receive flags do not follow inputs");
endmodule // usbifc_chk
bind usbifc_top usbifc_chk u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .differential_receive_in(differential_receive_in), .dminus_receive_in(dminus_receive_in),
   .dplus_receive_in(dplus_receive_in), .receive_active_input_in(receive_active_input_in),
   .receive_error_input_in(receive_error_input_in),
   .external_vbus_indicator_out(external_vbus_indicator_out),
   .external_vbus_drive_out(external_vbus_drive_out), .vbus_charge_out(vbus_charge_out),
   .vbus_discharge_out(vbus_discharge_out), .dminus_pulldown_out(dminus_pulldown_out),
   .dplus_pulldown_out(dplus_pulldown_out), .id_pin_pullup_out(id_pin_pullup_out),
   .transmit_single_ended_zero_out(transmit_single_ended_zero_out),
   .serial_transmit_data_out(serial_transmit_data_out),
   .serial_transmit_enable_low_out(serial_transmit_enable_low_out),
   .full_low_speed_serial_out(full_low_speed_serial_out));
`default_nettype wire

// ---- tb/usbifc_xcvr_model.sv ----
// Behavioural transceiver: session, receive, line state and packet events.
// Assumes the bench sets wanted levels on drive_in; outputs move only after an edge.
`timescale 1ns/1ps
`default_nettype none
module usbifc_xcvr_model (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // Wanted levels
   input  wire logic [14:0] drive_in,
   // Transceiver signals
   output var  logic [5:0]  session_out,
   output var  logic [2:0]  rx_lines_out,
   output var  logic [1:0]  line_state_out,
   output var  logic [3:0]  rx_events_out
);
   // Idle bus rests at J, so a J flag shows up right after reset
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         {session_out, rx_lines_out, line_state_out, rx_events_out} <= {9'h0, 2'h1, 4'h0};
      end else begin
         {session_out, rx_lines_out, line_state_out, rx_events_out} <= drive_in;
      end
   end
endmodule // usbifc_xcvr_model
`default_nettype wire

// ---- tb/tb.sv ----
// Register-level bench of the USB interface control block.
// Assumes usbifc_defs.vh on the include path and the transceiver model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "usbifc_defs.vh"
module tb;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic [7:0]  addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic [14:0] drv = {9'h0, `USBIFC_LS_J, 4'h0};
   wire  [31:0] rdata_out;
   wire  [5:0]  sess;
   wire  [2:0]  rxl;
   wire  [1:0]  ls;
   wire  [3:0]  ev;
   wire  [10:0] ctl;
   wire         irq_out;
   int          errors = 0;
   int          samples_checked = 0;
   always #5 clk_in = ~clk_in;
   usbifc_xcvr_model xcvr (.clk_in(clk_in), .resetn_in(resetn_in), .drive_in(drv),
      .session_out(sess), .rx_lines_out(rxl), .line_state_out(ls), .rx_events_out(ev));
   usbifc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .bvalid_in(sess[5]), .id_ground_in(sess[4]), .host_disconnect_in(sess[3]),
      .vbus_valid_in(sess[2]), .session_valid_in(sess[1]), .session_end_in(sess[0]),
      .differential_receive_in(rxl[2]), .dminus_receive_in(rxl[1]), .dplus_receive_in(rxl[0]),
      .line_state_in(ls), .receive_active_input_in(ev[3]), .receive_error_input_in(ev[2]),
      .token_ok_in(ev[1]), .crc16_fail_in(ev[0]), .external_vbus_indicator_out(ctl[10]),
      .external_vbus_drive_out(ctl[9]), .vbus_charge_out(ctl[8]), .vbus_discharge_out(ctl[7]),
      .dminus_pulldown_out(ctl[6]), .dplus_pulldown_out(ctl[5]), .id_pin_pullup_out(ctl[4]),
      .transmit_single_ended_zero_out(ctl[3]), .serial_transmit_data_out(ctl[2]),
      .serial_transmit_enable_low_out(ctl[1]), .full_low_speed_serial_out(ctl[0]),
      .irq_out(irq_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(rdata_out, exp);
   endtask
   task automatic put(input logic [14:0] v, input int n);
      @(posedge clk_in);
      drv <= v;
      repeat (n) @(posedge clk_in);
      // Let the edge's register updates settle before any compare
      #1;
   endtask
   task automatic stop_test;
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      rd(8'h10, 32'h0);
      rd(8'h18, 32'h2);
      rd(8'h14, 32'h0);
      rd(8'h1C, 32'h8);
      rd(8'h04, 32'h0);
      chk({21'h0, ctl}, 32'h2);
      wr(8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'hDF);
      chk({21'h0, ctl}, 32'h7F2);
      wr(8'h10, 32'h0);
      wr(8'h18, 32'h5);
      put({6'h2A, 3'h5, `USBIFC_LS_J, 4'h0}, 3);
      rd(8'h14, 32'h2A);
      rd(8'h18, 32'h55);
      chk({21'h0, ctl}, 32'h5);
      wr(8'h18, 32'hA);
      rd(8'h18, 32'h5A);
      chk({21'h0, ctl}, 32'hA);
      wr(8'h20, 32'h74);
      rd(8'h20, 32'h74);
      put({9'h0, `USBIFC_LS_SE0, 4'h3}, 1);
      put({9'h0, `USBIFC_LS_K, 4'h0}, 1);
      put({9'h0, 2'h3, 4'h0}, 3);
      rd(8'h1C, 32'h7C);
      put({9'h0, 2'h3, 4'h8}, 3);
      rd(8'h1C, 32'h76);
      wr(8'h1C, 32'h50);
      rd(8'h1C, 32'h26);
      wr(8'h20, 32'h0);
      put({9'h0, `USBIFC_LS_K, 4'h4}, 3);
      rd(8'h1C, 32'h35);
      put({9'h0, 2'h3, 4'h8}, 3);
      rd(8'h1C, 32'h2);
      rd(8'h24, 32'h7F);
      chk({31'h0, irq_out}, 32'h0);
      rd(8'h24, 32'h0);
      wr(8'h28, 32'h10);
      put({9'h0, `USBIFC_LS_J, 4'h0}, 3);
      chk({31'h0, irq_out}, 32'h0);
      put({9'h0, `USBIFC_LS_K, 4'h0}, 4);
      chk({31'h0, irq_out}, 32'h1);
      rd(8'h24, 32'h18);
      rd(8'h24, 32'h0);
      chk({31'h0, irq_out}, 32'h0);
      stop_test();
   end
   // Tests need about 90 cycles; twenty times that means a hang
   initial begin
      #20000;
      errors++;
      stop_test();
   end
endmodule // tb
`default_nettype wire
